// File: hdl/rsc_map.vh
`ifndef RSC_MAP_VH
`define RSC_MAP_VH
// Register byte offsets
`define RSC_OFF_STATUS   8'h00
`define RSC_OFF_MODE     8'h04
`define RSC_OFF_CAUSE    8'h08
`define RSC_OFF_INT_STAT 8'h0C
`define RSC_OFF_INT_MASK 8'h10
`define RSC_OFF_CTRL     8'h14
// Status fields
`define RSC_ST_TIMEOUT   0
`define RSC_ST_POWERDOWN 1
// Power modes
`define RSC_MODE_FAST    2'h0
`define RSC_MODE_SLOW    2'h1
`define RSC_MODE_IDLE    2'h2
`define RSC_MODE_SLEEP   2'h3
// Reset cause codes
`define RSC_CAUSE_NONE   2'h0
`define RSC_CAUSE_POR    2'h1
`define RSC_CAUSE_LVR    2'h2
`define RSC_CAUSE_WDT    2'h3
// Cause register fields
`define RSC_CA_CODE_LSB  0
`define RSC_CA_MODE_LSB  2
`define RSC_CA_SLEEPWDT  4
// Event bits in interrupt status and mask
`define RSC_EV_POR       0
`define RSC_EV_LVR       1
`define RSC_EV_WDT_RUN   2
`define RSC_EV_WDT_SLEEP 3
// Control fields
`define RSC_CT_INT_EN    0
`define RSC_CT_TMR_EN    1
`define RSC_CT_IO_OUT    2
// Reset values
`define RSC_RST_MODE     2'h0
`define RSC_RST_CTRL     3'h0
`define RSC_RST_MASK     4'h0
`endif

// File: hdl/rsc_cause_decode.v
`include "rsc_map.vh"
// Picks the winning reset source and the flag values it leaves behind
module rsc_cause_decode (
	input  wire       por_event,
	input  wire       lvr_event,
	input  wire       wdt_event,
	input  wire [1:0] mode,
	input  wire       timeout_in,
	input  wire       powerdown_in,
	output reg  [1:0] cause,
	output reg        sleep_wdt,
	output reg        timeout_out,
	output reg        powerdown_out
);
	wire low_power;

	assign low_power = (mode == `RSC_MODE_IDLE) || (mode == `RSC_MODE_SLEEP);

	// Power-on dominates; the voltage monitor is off while idle or sleeping
	always @* begin
		cause         = `RSC_CAUSE_NONE;
		sleep_wdt     = 1'b0;
		timeout_out   = timeout_in;
		powerdown_out = powerdown_in;
		if (por_event) begin
			cause         = `RSC_CAUSE_POR;
			timeout_out   = 1'b0;
			powerdown_out = 1'b0;
		end else if (lvr_event && !low_power) begin
			cause = `RSC_CAUSE_LVR;
		end else if (wdt_event) begin
			cause       = `RSC_CAUSE_WDT;
			timeout_out = 1'b1;
			if (low_power) begin
				sleep_wdt     = 1'b1;
				powerdown_out = 1'b1;
			end
		end
	end
endmodule

// File: hdl/rsc_reset_state_control.v
// Implementation choices: the APB slave port and the address map.
`include "rsc_map.vh"

// Reset sources arrive as one-cycle requests on por_event, lvr_event
// and wdt_event. A request held high for several cycles is taken as
// several requests, one per edge.
// Priority is power-on, then low voltage, then watchdog. The voltage
// monitor is off while idle or sleeping, so a low voltage request in
// those modes is dropped without trace.
// A watchdog while idle or sleeping only restarts the core: program
// counter and stack pointer clear and both flags are set. The control
// bits, the mask and the pin directions stay as software left them.
// All register effects land at the edge that takes the request. The
// pulses toward the core come from flip-flops loaded at that same edge.
// Limitation: the bus reset input clears every register, the mask
// included, whereas a power-on request leaves the mask alone.
module rsc_reset_state_control (
	input  wire        clock,
	input  wire        reset,
	input  wire        por_event,
	input  wire        lvr_event,
	input  wire        wdt_event,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output reg         irq,
	output reg         timeout_flag,
	output reg         powerdown_flag,
	output reg         pc_clear,
	output reg         sp_clear,
	output reg         sp_top,
	output reg         core_reset,
	output reg         watchdog_timer_clear,
	output reg         time_base_clear,
	output reg         watchdog_timer_run,
	output reg         int_enable,
	output reg         timer_enable,
	output reg         io_output_enable
);
	// Register state
	reg  [1:0] mode_q;
	reg  [1:0] mode_d;
	reg  [4:0] cause_q;
	reg  [4:0] cause_d;
	reg  [3:0] int_stat_q;
	reg  [3:0] int_stat_d;
	reg  [3:0] int_mask_q;
	reg  [3:0] int_mask_d;
	reg  [2:0] ctrl_q;
	reg  [2:0] ctrl_d;
	reg        timeout_d;
	reg        powerdown_d;
	reg  [31:0] rdata_d;
	reg        err_d;
	reg  [3:0] events;

	wire       setup_phase;
	wire       wr_take;
	wire [1:0] cause_now;
	wire       sleep_wdt_now;
	wire       timeout_next;
	wire       powerdown_next;
	wire       any_reset;
	wire       full_reset;
	wire       wr_mode;
	wire       wr_ctrl;
	wire       wr_stat;
	wire       wr_mask;
	wire       sleep_entry;

	// Write strobe for one register offset, taken at the access edge
	function write_hit;
		input       take;
		input [7:0] addr;
		input [7:0] offset;
		begin
			write_hit = take && (addr == offset);
		end
	endfunction

	// Address decode used by both the read and the write path
	function mapped;
		input [7:0] addr;
		begin
			mapped = (addr == `RSC_OFF_STATUS) || (addr == `RSC_OFF_MODE) ||
			         (addr == `RSC_OFF_CAUSE) || (addr == `RSC_OFF_INT_STAT) ||
			         (addr == `RSC_OFF_INT_MASK) || (addr == `RSC_OFF_CTRL);
		end
	endfunction

	assign setup_phase = psel && !penable;
	// Writes land at the access edge, with pready already high
	assign wr_take     = psel && penable && pready && pwrite;

	// Source and mode are sampled in the same cycle the event arrives
	rsc_cause_decode u_decode (
		.por_event     (por_event),
		.lvr_event     (lvr_event),
		.wdt_event     (wdt_event),
		.mode          (mode_q),
		.timeout_in    (timeout_flag),
		.powerdown_in  (powerdown_flag),
		.cause         (cause_now),
		.sleep_wdt     (sleep_wdt_now),
		.timeout_out   (timeout_next),
		.powerdown_out (powerdown_next)
	);

	assign any_reset  = (cause_now != `RSC_CAUSE_NONE);
	// A running watchdog reset is a full reset, the same as low voltage
	assign full_reset = any_reset && !sleep_wdt_now;

	// Per-register write strobes; each lands once, at the access edge
	assign wr_mode     = write_hit(wr_take, paddr, `RSC_OFF_MODE);
	assign wr_ctrl     = write_hit(wr_take, paddr, `RSC_OFF_CTRL);
	assign wr_stat     = write_hit(wr_take, paddr, `RSC_OFF_INT_STAT);
	assign wr_mask     = write_hit(wr_take, paddr, `RSC_OFF_INT_MASK);
	// Software entering idle or sleep; a reset in the same cycle still wins
	assign sleep_entry = wr_mode && (pwdata[1:0] == `RSC_MODE_IDLE || pwdata[1:0] == `RSC_MODE_SLEEP);

	// Event vector for the sticky interrupt status
	always @* begin
		events = 4'h0;
		events[`RSC_EV_POR]       = (cause_now == `RSC_CAUSE_POR);
		events[`RSC_EV_LVR]       = (cause_now == `RSC_CAUSE_LVR);
		events[`RSC_EV_WDT_RUN]   = (cause_now == `RSC_CAUSE_WDT) && !sleep_wdt_now;
		events[`RSC_EV_WDT_SLEEP] = sleep_wdt_now;
	end

	// Flags: reset events win over software mode entry
	always @* begin
		timeout_d   = timeout_flag;
		powerdown_d = powerdown_flag;
		if (any_reset) begin
			timeout_d   = timeout_next;
			powerdown_d = powerdown_next;
		end else if (sleep_entry) begin
			// Entering a low power mode marks power-down and clears time-out
			timeout_d   = 1'b0;
			powerdown_d = 1'b1;
		end
	end

	// Mode: a full reset returns to fast; a sleeping watchdog wakes to fast too
	// The old mode is still in mode_q this cycle, so the decoder sees the
	// mode that was in force when the request arrived
	always @* begin
		mode_d = mode_q;
		if (any_reset)
			mode_d = `RSC_MODE_FAST;
		else if (wr_mode)
			mode_d = pwdata[1:0];
	end

	// Cause record holds the mode that was in force when the reset hit
	always @* begin
		cause_d = cause_q;
		if (any_reset)
			cause_d = {sleep_wdt_now, mode_q, cause_now};
	end

	// Control: full resets drop interrupts, timers and pin drive
	always @* begin
		ctrl_d = ctrl_q;
		if (full_reset)
			ctrl_d = `RSC_RST_CTRL;
		else if (wr_ctrl)
			ctrl_d = pwdata[2:0];
	end

	// Sticky events; a set in the clearing cycle survives
	// Clearing first and setting after keeps an event that races a
	// software clear, so no reset cause is ever lost
	always @* begin
		int_stat_d = int_stat_q;
		if (wr_stat)
			int_stat_d = int_stat_q & ~pwdata[3:0];
		int_stat_d = int_stat_d | events;
	end

	// Mask survives everything but the bus reset, so wake causes stay visible
	always @* begin
		int_mask_d = int_mask_q;
		if (wr_mask)
			int_mask_d = pwdata[3:0];
	end

	// Read data is prepared in setup so the access phase needs no wait
	always @* begin
		rdata_d = 32'h0000_0000;
		err_d   = !mapped(paddr);
		case (paddr)
			`RSC_OFF_STATUS: begin
				rdata_d[`RSC_ST_TIMEOUT]   = timeout_flag;
				rdata_d[`RSC_ST_POWERDOWN] = powerdown_flag;
			end
			`RSC_OFF_MODE:     rdata_d[1:0] = mode_q;
			`RSC_OFF_CAUSE:    rdata_d[4:0] = cause_q;
			`RSC_OFF_INT_STAT: rdata_d[3:0] = int_stat_q;
			`RSC_OFF_INT_MASK: rdata_d[3:0] = int_mask_q;
			`RSC_OFF_CTRL:     rdata_d[2:0] = ctrl_q;
			default:           rdata_d = 32'h0000_0000;
		endcase
	end

	// Bus slave timing: one setup, one access cycle
	// Read data is latched at setup, so a value that changes during the
	// access cycle shows on the next read, not this one
	always @(posedge clock) begin
		if (reset) begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_phase;
			pslverr <= setup_phase && err_d;
			if (setup_phase && !pwrite)
				prdata <= rdata_d;
			else if (!psel)
				prdata <= 32'h0000_0000;
		end
	end

	// Register state update
	always @(posedge clock) begin
		if (reset) begin
			mode_q         <= `RSC_RST_MODE;
			cause_q        <= 5'h00;
			int_stat_q     <= 4'h0;
			int_mask_q     <= `RSC_RST_MASK;
			ctrl_q         <= `RSC_RST_CTRL;
			timeout_flag   <= 1'b0;
			powerdown_flag <= 1'b0;
		end else begin
			mode_q         <= mode_d;
			cause_q        <= cause_d;
			int_stat_q     <= int_stat_d;
			int_mask_q     <= int_mask_d;
			ctrl_q         <= ctrl_d;
			timeout_flag   <= timeout_d;
			powerdown_flag <= powerdown_d;
		end
	end

	// Effect pulses toward the core, one cycle after the event
	// Registered so the core sees clean one-cycle strobes; they change
	// at the same edge as the flag update
	always @(posedge clock) begin
		if (reset) begin
			pc_clear             <= 1'b0;
			sp_clear             <= 1'b0;
			sp_top               <= 1'b0;
			core_reset           <= 1'b0;
			watchdog_timer_clear <= 1'b0;
			time_base_clear      <= 1'b0;
		end else begin
			pc_clear             <= any_reset;
			sp_clear             <= sleep_wdt_now;
			sp_top               <= full_reset;
			core_reset           <= full_reset;
			watchdog_timer_clear <= full_reset;
			time_base_clear      <= full_reset;
		end
	end

	// Level outputs; watchdog keeps counting straight after its clear
	// The enables follow the next control value, so a write or a reset
	// clear reaches the pins at the same edge as the register
	always @(posedge clock) begin
		if (reset) begin
			watchdog_timer_run <= 1'b0;
			int_enable         <= 1'b0;
			timer_enable       <= 1'b0;
			io_output_enable   <= 1'b0;
			irq                <= 1'b0;
		end else begin
			watchdog_timer_run <= 1'b1;
			int_enable         <= ctrl_d[`RSC_CT_INT_EN];
			timer_enable       <= ctrl_d[`RSC_CT_TMR_EN];
			io_output_enable   <= ctrl_d[`RSC_CT_IO_OUT];
			irq                <= |(int_stat_d & int_mask_d);
		end
	end
endmodule

// File: bench/rsc_reset_state_control_properties.sv
// Port-level checks of how each reset source leaves flags, and of the pulses after power-on and watchdog
module rsc_checker (
	input logic clock,
	input logic reset,
	input logic por_event,
	input logic lvr_event,
	input logic wdt_event,
	input logic psel,
	input logic timeout_flag,
	input logic powerdown_flag,
	input logic pc_clear,
	input logic sp_clear,
	input logic sp_top,
	input logic watchdog_timer_clear,
	input logic watchdog_timer_run,
	input logic timer_enable
);
	timeunit 1ns / 1ps;
	// One domain, so clock and reset are given once
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (reset);
	// A watchdog that wins; a low voltage request may outrank it in run mode
	wire wdt_only = wdt_event && !por_event && !lvr_event;
	wire lvr_only = lvr_event && !por_event && !wdt_event && !psel;
	property p_por_flags; por_event |=> !timeout_flag && !powerdown_flag; endproperty
	a_por_flags: assert property (p_por_flags) else $error("power-on left a flag");
	property p_wdt_to; wdt_only |=> timeout_flag; endproperty
	a_wdt_to: assert property (p_wdt_to) else $error("watchdog left timeout low");
	property p_lvr_keep; lvr_only |=> $stable(timeout_flag) && $stable(powerdown_flag); endproperty
	a_lvr_keep: assert property (p_lvr_keep) else $error("low voltage moved a flag");
	property p_sleep_wdt; sp_clear |-> pc_clear && timeout_flag && powerdown_flag; endproperty
	a_sleep_wdt: assert property (p_sleep_wdt) else $error("sleep watchdog state wrong");
	property p_sp_top; por_event |=> sp_top && pc_clear && !sp_clear; endproperty
	a_sp_top: assert property (p_sp_top) else $error("power-on stack or pc wrong");
	property p_wdt_clr; por_event |=> watchdog_timer_clear && watchdog_timer_run; endproperty
	a_wdt_clr: assert property (p_wdt_clr) else $error("watchdog not cleared and run");
	property p_tmr_off; por_event |=> !timer_enable; endproperty
	a_tmr_off: assert property (p_tmr_off) else $error("timer left on");
	property p_wdt_kind; wdt_only |=> sp_clear ^ sp_top; endproperty
	a_wdt_kind: assert property (p_wdt_kind) else $error("watchdog pulse kind wrong");
	c_sleep: cover property (sp_clear);
	c_lvr: cover property (lvr_only);
	c_run_wdt: cover property (wdt_only ##1 sp_top);
endmodule
bind rsc_reset_state_control rsc_checker u_chk (.clock, .reset, .por_event, .lvr_event, .wdt_event,
	.psel, .timeout_flag, .powerdown_flag, .pc_clear, .sp_clear, .sp_top, .watchdog_timer_clear,
	.watchdog_timer_run, .timer_enable);

// File: bench/tb_reset_state_control.sv
`include "rsc_map.vh"
// Random modes, controls and reset sources against a flag model
module tb_reset_state_control;
	timeunit 1ns / 1ps;
	logic        clock = 0, reset = 1, por_event = 0, lvr_event = 0, wdt_event = 0;
	logic        psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, se;
	logic        timeout_flag, powerdown_flag, int_enable, timer_enable, io_output_enable;
	logic        pc_clear, sp_clear, sp_top, core_reset, watchdog_timer_clear, time_base_clear, watchdog_timer_run;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	int          fail_count = 0, total_checks = 0, to_m = 0, pd_m = 0, md_m = 0, ct_m = 0, ca_m = 0, k, m;
	// Half period of the 4 ns clock
	always #2 clock = ~clock;
	rsc_reset_state_control uut (.clock, .reset, .por_event, .lvr_event, .wdt_event, .psel, .penable,
		.pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .timeout_flag, .powerdown_flag,
		.pc_clear, .sp_clear, .sp_top, .core_reset, .watchdog_timer_clear, .time_base_clear,
		.watchdog_timer_run, .int_enable, .timer_enable, .io_output_enable);
	task chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	// Request held until pready is sampled high; a stuck slave counts as a fault
	task apb(bit w, logic [7:0] a, logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1;
		do
			@(posedge clock);
		while (pready !== 1'b1 && n++ < 20);
		if (n > 20) fail_count++;
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Entering idle or sleep marks power-down and drops timeout
	task mo(int v);
		apb(1, `RSC_OFF_MODE, v);
		md_m = v;
		if (v > 1) to_m = 0;
		if (v > 1) pd_m = 1;
	endtask
	// One-cycle request; the model uses the mode held before it
	task ev(int s);
		bit lp, hit, slw;
		logic [5:0] pe;
		lp = md_m > 1;
		hit = !(s == 1 && lp);
		slw = s == 2 && lp;
		pe = {hit, slw, {4{hit && !slw}}};
		@(posedge clock);
		por_event <= s == 0;
		lvr_event <= s == 1;
		wdt_event <= s == 2;
		@(posedge clock);
		{por_event, lvr_event, wdt_event} <= 3'h0;
		if (s != 1) to_m = s == 2;
		if (s == 0) pd_m = 0;
		if (s == 2 && lp) pd_m = 1;
		if (!lp || s == 0) ct_m = 0;
		if (hit) ca_m = {slw, md_m[1:0], s[1:0] + 2'h1};
		if (!lp || s != 1) md_m = 0;
		@(negedge clock);
		chk("pulses", pe, {pc_clear, sp_clear, sp_top, core_reset, watchdog_timer_clear, time_base_clear});
		chk("wdt_run", 1, watchdog_timer_run);
	endtask
	// Read on the falling edge so the update edge has landed
	task look;
		@(negedge clock);
		chk("timeout_flag", to_m, timeout_flag);
		chk("powerdown_flag", pd_m, powerdown_flag);
		chk("ctrl", ct_m, {io_output_enable, timer_enable, int_enable});
		apb(0, `RSC_OFF_STATUS, 0);
		chk("status", pd_m * 2 + to_m, rd);
		apb(0, `RSC_OFF_CAUSE, 0);
		chk("cause", ca_m, rd);
	endtask
	task end_sim;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// Random sweep, then interrupt path and an unmapped access
	initial begin
		k = $urandom(32'h82141C59);
		repeat (16) @(posedge clock);
		reset <= 0;
		for (k = 0; k < 80; k++) begin
			m = $urandom_range(7);
			apb(1, `RSC_OFF_CTRL, m);
			ct_m = m;
			mo($urandom_range(3));
			ev($urandom_range(2));
			look;
		end
		apb(1, `RSC_OFF_INT_MASK, 32'h2);
		apb(1, `RSC_OFF_INT_STAT, 32'hF);
		mo(0);
		ev(1);
		look;
		chk("irq_set", 1, irq);
		ev(0);
		apb(1, `RSC_OFF_INT_STAT, 32'h2);
		repeat (3) @(posedge clock);
		chk("irq_clr", 0, irq);
		apb(0, 8'hFC, 32'h0);
		chk("pslverr", 1, se);
		chk("unmapped", 0, rd);
		end_sim;
	end
	// Cuts a hang well past the expected run
	initial begin
		#100000;
		fail_count++;
		end_sim;
	end
endmodule
